// File: design/dispense_controller_end.sv
// Controller end: issues command pulses with the required spacing.
`timescale 1ns/1ps
module dispense_controller_end
    import dispense_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES // Clock cycles per 10 ms tick.
) (
    input  wire logic clock,      // System clock, 40 MHz.
    input  wire logic rst_n,      // Asynchronous reset, active low.
    dispense_link_if.host link,   // Command and status lines.
    input  wire logic req,        // Request to send a command.
    input  cmd_t      req_cmd,    // Command to send with the request.
    output logic      busy,       // High from acceptance to the pulse end.
    output logic      ready_seen  // Status has been high for over 3 s.
);

    // Width of the tick prescaler.
    localparam int PW = $clog2(TICK_CYC + 1);

    // Controller states.
    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_PULSE} hstate_t;

    logic [PW-1:0]      prescale_ff; // Cycle count within one tick.
    logic               tick;        // One-cycle strobe every 10 ms.
    logic [WIDTH_W-1:0] ready_ff;    // Ticks with status continuously high.
    logic [SPACE_W-1:0] space_ff;    // Ticks of spacing still to wait.
    logic [WIDTH_W-1:0] pulse_ff;    // Ticks of the pulse driven so far.
    hstate_t            state_ff;    // Controller state.
    cmd_t               cmd_ff;      // Command being sent.
    logic               line_ff;     // Level driven on the command line.

    // Prescaler that divides the clock down to the 10 ms tick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prescale_ff <= '0;
        end else if (prescale_ff == PW'(TICK_CYC - 1)) begin
            prescale_ff <= '0;
        end else begin
            prescale_ff <= prescale_ff + PW'(1);
        end
    end

    assign tick = (prescale_ff == PW'(TICK_CYC - 1));

    // Watches how long the device status has stayed high.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_ff <= '0;
        end else if (!link.status) begin
            ready_ff <= '0;
        end else if (tick && ready_ff <= READY_T) begin
            ready_ff <= ready_ff + WIDTH_W'(1);
        end
    end

    // Ready condition as the device itself judges it.
    assign ready_seen = (ready_ff > READY_T);

    // Sends one pulse per request; all but an acknowledge wait until spacing and ready are satisfied.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= H_IDLE;
            cmd_ff   <= CMD_NONE;
            line_ff  <= 1'b0;
            pulse_ff <= '0;
            space_ff <= '0;
        end else begin
            // Spacing counts down between commands.
            if (tick && space_ff != '0) begin
                space_ff <= space_ff - SPACE_W'(1);
            end
            case (state_ff)
                H_IDLE: begin
                    if (req && req_cmd != CMD_NONE) begin
                        cmd_ff   <= req_cmd;
                        state_ff <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    // Acknowledge goes out at once; others wait for ready.
                    if (cmd_ff == CMD_ACK || (space_ff == '0 && ready_seen)) begin
                        line_ff  <= 1'b1;
                        pulse_ff <= '0;
                        state_ff <= H_PULSE;
                    end
                end
                H_PULSE: begin
                    if (tick) begin
                        if (pulse_ff == nominal_ticks(cmd_ff) - WIDTH_W'(1)) begin
                            // Pulse ends; an acknowledge keeps the spacing already running.
                            line_ff  <= 1'b0;
                            if (cmd_ff != CMD_ACK) begin
                                space_ff <= spacing_ticks(cmd_ff);
                            end
                            state_ff <= H_IDLE;
                        end else begin
                            pulse_ff <= pulse_ff + WIDTH_W'(1);
                        end
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    assign link.cmd = line_ff;
    assign busy     = (state_ff != H_IDLE);

endmodule

// File: design/dispense_link_if.sv
// Two-wire link between the controller end and the dispense device.
`timescale 1ns/1ps
interface dispense_link_if;
    logic cmd;    // Command line, driven high for the pulse length.
    logic status; // Status line, high when ready or in a gap.

    // Device end reads commands and drives status.
    modport device (input cmd, output status);

    // Controller end drives commands and reads status.
    modport host (output cmd, input status);
endinterface

// File: design/dispense_pkg.sv
// Shared constants, command codes and pulse decoding for the dispense link.
package dispense_pkg;

    // Clock and time base: one tick is 10 ms at a 25 ns clock period.
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_PERIOD_NS = 10_000_000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_MS        = 10;

    // Counter widths for pulse widths, run counts and spacing timers.
    localparam int WIDTH_W = 11;
    localparam int SPACE_W = 18;
    localparam int RUNS_W  = 7;

    // Accepted pulse windows in milliseconds.
    localparam int PB1_MIN_MS  = 1900;
    localparam int PB1_MAX_MS  = 2100;
    localparam int PB2_MIN_MS  = 4900;
    localparam int PB2_MAX_MS  = 5100;
    localparam int BOTH_MIN_MS = 7900;
    localparam int BOTH_MAX_MS = 8100;
    localparam int FILL_MIN_MS = 11900;
    localparam int FILL_MAX_MS = 12100;
    localparam int ACK_MIN_MS  = 13900;
    localparam int ACK_MAX_MS  = 14100;

    // Sequence timing in milliseconds.
    localparam int IGNORE_MS  = 15000;
    localparam int READY_MS   = 3000;
    localparam int GAP_MS     = 2000;
    localparam int RUN_MAX_MS = 17000;

    // The same figures expressed in 10 ms ticks.
    localparam logic [WIDTH_W-1:0] IGNORE_T  = WIDTH_W'(IGNORE_MS / TICK_MS);
    localparam logic [WIDTH_W-1:0] READY_T   = WIDTH_W'(READY_MS / TICK_MS);
    localparam logic [WIDTH_W-1:0] GAP_T     = WIDTH_W'(GAP_MS / TICK_MS);
    localparam logic [WIDTH_W-1:0] RUN_MAX_T = WIDTH_W'(RUN_MAX_MS / TICK_MS);

    // Nominal pulse lengths that the controller end drives.
    localparam int PB1_NOM_MS  = 2000;
    localparam int PB2_NOM_MS  = 5000;
    localparam int BOTH_NOM_MS = 8000;
    localparam int FILL_NOM_MS = 12000;
    localparam int ACK_NOM_MS  = 14000;

    // Least spacing from the end of a command pulse to the next start, in milliseconds.
    localparam int PB1_SPACE_MS  = 22000;
    localparam int PB2_SPACE_MS  = 25000;
    localparam int BOTH_SPACE_MS = 47000;
    localparam int FILL_SPACE_MS = 1533000;

    // Number of motor runs per command.
    localparam int FILL_PER_BODY = 40;
    localparam logic [RUNS_W-1:0] RUNS_ONE  = RUNS_W'(1);
    localparam logic [RUNS_W-1:0] RUNS_TWO  = RUNS_W'(2);
    localparam logic [RUNS_W-1:0] RUNS_FILL = RUNS_W'(2 * FILL_PER_BODY);

    // Pump body selection.
    localparam logic BODY_FIRST  = 1'b0;
    localparam logic BODY_SECOND = 1'b1;

    // Command codes carried by the pulse length.
    typedef enum logic [2:0] {
        CMD_NONE, CMD_PB1, CMD_PB2, CMD_BOTH, CMD_FILL, CMD_ACK
    } cmd_t;

    // Classifies a measured width in ticks into a command code.
    function automatic cmd_t decode_width(input logic [WIDTH_W-1:0] w);
        cmd_t c;
        c = CMD_NONE;
        if (w >= WIDTH_W'(PB1_MIN_MS / TICK_MS) && w <= WIDTH_W'(PB1_MAX_MS / TICK_MS))
            c = CMD_PB1;
        if (w >= WIDTH_W'(PB2_MIN_MS / TICK_MS) && w <= WIDTH_W'(PB2_MAX_MS / TICK_MS))
            c = CMD_PB2;
        if (w >= WIDTH_W'(BOTH_MIN_MS / TICK_MS) && w <= WIDTH_W'(BOTH_MAX_MS / TICK_MS))
            c = CMD_BOTH;
        if (w >= WIDTH_W'(FILL_MIN_MS / TICK_MS) && w <= WIDTH_W'(FILL_MAX_MS / TICK_MS))
            c = CMD_FILL;
        if (w >= WIDTH_W'(ACK_MIN_MS / TICK_MS) && w <= WIDTH_W'(ACK_MAX_MS / TICK_MS))
            c = CMD_ACK;
        return c;
    endfunction

    // Nominal pulse length in ticks for a command.
    function automatic logic [WIDTH_W-1:0] nominal_ticks(input cmd_t c);
        logic [WIDTH_W-1:0] t;
        t = WIDTH_W'(PB1_NOM_MS / TICK_MS);
        case (c)
            CMD_PB2:  t = WIDTH_W'(PB2_NOM_MS / TICK_MS);
            CMD_BOTH: t = WIDTH_W'(BOTH_NOM_MS / TICK_MS);
            CMD_FILL: t = WIDTH_W'(FILL_NOM_MS / TICK_MS);
            CMD_ACK:  t = WIDTH_W'(ACK_NOM_MS / TICK_MS);
            default:  t = WIDTH_W'(PB1_NOM_MS / TICK_MS);
        endcase
        return t;
    endfunction

    // Least spacing in ticks after a command; acknowledge needs none.
    function automatic logic [SPACE_W-1:0] spacing_ticks(input cmd_t c);
        logic [SPACE_W-1:0] t;
        t = '0;
        case (c)
            CMD_PB1:  t = SPACE_W'(PB1_SPACE_MS / TICK_MS);
            CMD_PB2:  t = SPACE_W'(PB2_SPACE_MS / TICK_MS);
            CMD_BOTH: t = SPACE_W'(BOTH_SPACE_MS / TICK_MS);
            CMD_FILL: t = SPACE_W'(FILL_SPACE_MS / TICK_MS);
            default:  t = '0;
        endcase
        return t;
    endfunction

endpackage

// File: design/pulse_length_dispense_control.sv
// Device end: decodes command pulse lengths and sequences motor runs.
// Summary of operation
// - 4.9 to 5.1 s pulse: one stroke second body.
// - Accept only after status high over 3 s.
// - Falling edge starts run; status low during run.
// - Runs of 7 to 17 s all tolerated.
// - Good single run returns status high.
// - Ignore commands within 3 s after run.
// - Controller spaces 5 s command by 25 s.
// - 7.9 to 8.1 s pulse: both bodies, two runs.
// - Dual command: 2 s high gap between runs.
// - Controller spaces 8 s command by 47 s.
// - 11.9 to 12.1 s pulse: 40 runs per body.
// - Bulk fill: 2 s high gap between runs.
// - Controller spaces 12 s command by 1533 s.
// - 14 s pulse in gap stops bulk fill.
// - Run fault holds status low, not high.
// - Ignore pulses over 15 s or off-window.
// - 2 s pulse: one stroke first body, 22 s spacing.
// - 14 s pulse acknowledges error while status low; status returns high only if the self check passes.
`timescale 1ns/1ps
module pulse_length_dispense_control
    import dispense_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES // Clock cycles per 10 ms tick.
) (
    input  wire logic clock,        // System clock, 40 MHz.
    input  wire logic rst_n,        // Asynchronous reset, active low.
    dispense_link_if.device link,   // Command and status lines.
    output logic      motor_run,    // High while the motor must turn.
    output logic      motor_body,   // Pump body of the current run.
    input  wire logic motor_done,   // One-cycle pulse at the end of a run.
    input  wire logic motor_fault,  // Fault seen during or right after the run.
    input  wire logic check_ok,     // Result of the internal self check.
    output logic      fill_active,  // High during a bulk fill sequence.
    output cmd_t      last_cmd      // Last command that was acted upon.
);

    // Width of the tick prescaler.
    localparam int PW = $clog2(TICK_CYC + 1);

    // Sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP, ST_ERR} state_t;

    logic [PW-1:0]      prescale_ff;  // Cycle count within one tick.
    logic               tick;         // One-cycle strobe every 10 ms.
    logic               cmd_d_ff;     // Command line one cycle late.
    logic               cmd_fall;     // Falling edge of the command line.
    logic [WIDTH_W-1:0] width_ff;     // Pulse width in ticks, saturating.
    cmd_t               decoded;      // Command implied by the width.
    logic [WIDTH_W-1:0] ready_ff;     // Ticks with status continuously high.
    logic               ready_ok;     // Status has been high over 3 s.
    state_t             state_ff;     // Sequencer state.
    logic [WIDTH_W-1:0] timer_ff;     // Ticks spent in the current run or gap.
    logic [RUNS_W-1:0]  runs_left_ff; // Runs still to do, this one included.

    // Prescaler that divides the clock down to the 10 ms tick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prescale_ff <= '0;
        end else if (prescale_ff == PW'(TICK_CYC - 1)) begin
            prescale_ff <= '0;
        end else begin
            prescale_ff <= prescale_ff + PW'(1);
        end
    end

    // The tick strobes once per wrap of the prescaler.
    assign tick = (prescale_ff == PW'(TICK_CYC - 1));

    // Edge detect on the command line, which is synchronous to the clock.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_d_ff <= 1'b0;
        end else begin
            cmd_d_ff <= link.cmd;
        end
    end

    // A falling edge closes the measured pulse.
    assign cmd_fall = cmd_d_ff & ~link.cmd;

    // Pulse width counter in 10 ms steps; it saturates so that long levels
    // can never wrap around into a valid window.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            width_ff <= '0;
        end else if (link.cmd) begin
            if (tick && width_ff <= IGNORE_T) begin
                width_ff <= width_ff + WIDTH_W'(1);
            end
        end else if (!cmd_d_ff) begin
            // Line idle low: clear ready for the next pulse.
            width_ff <= '0;
        end
    end

    // Widths outside every window, including any over 15 s, decode to none.
    assign decoded = decode_width(width_ff);

    // Ready timer: counts only while the status line stays high.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_ff <= '0;
        end else if (!link.status) begin
            // Any low period, such as a run, restarts the wait.
            ready_ff <= '0;
        end else if (tick && ready_ff <= READY_T) begin
            ready_ff <= ready_ff + WIDTH_W'(1);
        end
    end

    // Commands in idle count only once status has been high for more than 3 s.
    assign ready_ok = (ready_ff > READY_T);

    // Sequencer: decodes commands, runs the motor, times gaps and errors.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= ST_IDLE;
            timer_ff     <= '0;
            runs_left_ff <= '0;
            motor_body   <= BODY_FIRST;
            fill_active  <= 1'b0;
            last_cmd     <= CMD_NONE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    timer_ff <= '0;
                    // A command is taken on the falling edge, only when ready.
                    if (cmd_fall && ready_ok) begin
                        case (decoded)
                            CMD_PB1: begin
                                // One stroke on the first body.
                                state_ff     <= ST_RUN;
                                runs_left_ff <= RUNS_ONE;
                                motor_body   <= BODY_FIRST;
                                last_cmd     <= CMD_PB1;
                            end
                            CMD_PB2: begin
                                // One stroke on the second body.
                                state_ff     <= ST_RUN;
                                runs_left_ff <= RUNS_ONE;
                                motor_body   <= BODY_SECOND;
                                last_cmd     <= CMD_PB2;
                            end
                            CMD_BOTH: begin
                                // First body, then the second after a gap.
                                state_ff     <= ST_RUN;
                                runs_left_ff <= RUNS_TWO;
                                motor_body   <= BODY_FIRST;
                                last_cmd     <= CMD_BOTH;
                            end
                            CMD_FILL: begin
                                // Alternating runs, forty on each body.
                                state_ff     <= ST_RUN;
                                runs_left_ff <= RUNS_FILL;
                                motor_body   <= BODY_FIRST;
                                fill_active  <= 1'b1;
                                last_cmd     <= CMD_FILL;
                            end
                            default: begin
                                // Acknowledge while ready and unknown widths
                                // have no effect.
                                state_ff <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        timer_ff <= timer_ff + WIDTH_W'(1);
                    end
                    if (motor_done) begin
                        timer_ff <= '0;
                        if (motor_fault) begin
                            // A fault holds status low instead of high.
                            state_ff    <= ST_ERR;
                            fill_active <= 1'b0;
                        end else if (runs_left_ff == RUNS_ONE) begin
                            // Last good run: back to ready, status high.
                            state_ff    <= ST_IDLE;
                            fill_active <= 1'b0;
                        end else begin
                            // More runs follow after a high gap.
                            state_ff     <= ST_GAP;
                            runs_left_ff <= runs_left_ff - RUNS_W'(1);
                            motor_body   <= ~motor_body;
                        end
                    end else if (timer_ff > RUN_MAX_T) begin
                        // Runs up to 17 s are normal; beyond that the motor
                        // is taken to have failed.
                        state_ff    <= ST_ERR;
                        fill_active <= 1'b0;
                    end
                end
                ST_GAP: begin
                    if (cmd_fall && decoded == CMD_ACK) begin
                        // Acknowledge in a gap ends the sequence, no more runs.
                        state_ff     <= ST_IDLE;
                        timer_ff     <= '0;
                        runs_left_ff <= '0;
                        fill_active  <= 1'b0;
                        last_cmd     <= CMD_ACK;
                    end else if (tick) begin
                        if (timer_ff == GAP_T - WIDTH_W'(1)) begin
                            // Gap of 2 s over: the next run starts low.
                            state_ff <= ST_RUN;
                            timer_ff <= '0;
                        end else begin
                            timer_ff <= timer_ff + WIDTH_W'(1);
                        end
                    end
                end
                ST_ERR: begin
                    timer_ff <= '0;
                    // Only the acknowledge is heard while status is low.
                    if (cmd_fall && decoded == CMD_ACK) begin
                        last_cmd <= CMD_ACK;
                        if (check_ok) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Status is high when ready or in a gap, low during runs and errors.
    assign link.status = (state_ff == ST_IDLE) || (state_ff == ST_GAP);

    // The motor turns for the whole run state.
    assign motor_run = (state_ff == ST_RUN);

endmodule

// File: verification/dispense_link_props.sv
// Properties of the command and status lines of the dispense link.
`timescale 1ns/1ps
module dispense_link_props #(
    parameter int TICK_CYC = 4 // Clock cycles per tick.
) (
    input wire logic clock,  // System clock.
    input wire logic rst_n,  // Reset, active low.
    input wire logic cmd,    // Command line.
    input wire logic status  // Status line.
);
    localparam int T = TICK_CYC;
    int   hi_ff, wd_ff, hr_ff; // Status high run, pulse width, status high at pulse start.
    int   sec, err;            // Pulse width in seconds and the remainder in cycles.
    logic ok;                  // Pulse has a nominal command length.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Measures the stretches that the properties judge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_ff <= 0;
            wd_ff <= 0;
            hr_ff <= 0;
        end else begin
            hi_ff <= status ? hi_ff + 1 : 0;
            wd_ff <= cmd ? wd_ff + 1 : 0;
            hr_ff <= (cmd && wd_ff == 0) ? hi_ff : hr_ff;
        end
    end
    assign sec = (wd_ff + 50 * T) / (100 * T);
    assign err = wd_ff - sec * 100 * T;
    assign ok  = sec inside {2, 5, 8, 12, 14} && err >= -2 * T && err <= T;
    a_reset_lines_idle: assert property ($rose(rst_n) |-> status && !cmd)
        else $error("lines not idle after reset");
    a_pulse_length_ok: assert property ($fell(cmd) |-> ok)
        else $error("pulse length off nominal");
    a_ready_at_start: assert property ($rose(cmd) && status && hi_ff >= 250 * T |->
        hi_ff >= 299 * T) else $error("pulse started before ready");
    a_run_on_fall: assert property ($fell(cmd) && ok && sec != 14 && hr_ff > 302 * T
        |-> ##[1:3] !status) else $error("no run after valid pulse");
    a_gap_two_seconds: assert property ($fell(status) && hi_ff < 250 * T |->
        hi_ff >= 199 * T && hi_ff <= 201 * T) else $error("gap length wrong");
    a_run_after_ready: assert property ($fell(status) && hi_ff >= 250 * T |->
        hr_ff >= 299 * T) else $error("run without ready time");
    a_run_after_cmd: assert property ($fell(status) && hi_ff >= 250 * T |->
        $past(cmd, 2) || $past(cmd, 3)) else $error("run without pulse end");
    a_ack_stops_fill: assert property ($fell(cmd) && ok && sec == 14 && status |->
        ##1 status [*8]) else $error("run after stop pulse");
    a_run_stays_low: assert property ($fell(status) |-> !status [*8])
        else $error("run too short");
    c_gap_seen: cover property ($fell(status) && hi_ff < 250 * T);
    c_ack_in_gap: cover property ($fell(cmd) && sec == 14 && status);
    c_dual_pulse: cover property ($fell(cmd) && sec == 8 && ok);
endmodule

// File: verification/pulse_length_dispense_control_tb_top.sv
// Testbench joining the controller end and the device end over the link.
`timescale 1ns/1ps
module pulse_length_dispense_control_tb_top;
    import dispense_pkg::*;
    localparam int T = 4;                   // Clock cycles per tick.
    logic   clock = 1'b0;                   // 40 MHz clock.
    logic   rst_n = 1'b0;                   // Reset, active low.
    logic   req = 1'b0, motor_done = 1'b0, motor_fault = 1'b0, check_ok = 1'b1;
    cmd_t   req_cmd = CMD_NONE;             // Command for the controller end.
    logic   busy, ready_seen, motor_run, motor_body, fill_active;
    cmd_t   last_cmd;                       // Last command acted upon.
    int     fails = 0, checks_done = 0;     // Mismatches and comparisons.
    longint rise_t, fall_t, mark_t;         // Pulse edge times.
    dispense_link_if link ();               // Link between both ends.
    dispense_link_if spare ();              // Link driven by the bench.
    dispense_controller_end #(.TICK_CYC(T)) u_dispense_controller_end (.clock(clock),
        .rst_n(rst_n), .link(link.host), .req(req), .req_cmd(req_cmd), .busy(busy),
        .ready_seen(ready_seen));
    pulse_length_dispense_control #(.TICK_CYC(T)) u_pulse_length_dispense_control (
        .clock(clock), .rst_n(rst_n), .link(link.device), .motor_run(motor_run),
        .motor_body(motor_body), .motor_done(motor_done), .motor_fault(motor_fault),
        .check_ok(check_ok), .fill_active(fill_active), .last_cmd(last_cmd));
    pulse_length_dispense_control #(.TICK_CYC(T)) u_pulse_length_dispense_control_b (
        .clock(clock), .rst_n(rst_n), .link(spare.device), .motor_run(), .motor_body(),
        .motor_done(1'b0), .motor_fault(1'b0), .check_ok(1'b1), .fill_active(), .last_cmd());
    dispense_link_props #(.TICK_CYC(T)) u_dispense_link_props (.clock(clock),
        .rst_n(rst_n), .cmd(link.cmd), .status(link.status));
    // Free-running clock.
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compares one value and counts the result.
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    // Waits for status, busy, motor run or command line; running out is a mismatch.
    task automatic wait_for(int sel, logic v, int lim);
        logic s;
        for (int i = 0; i <= lim; i++) begin
            @(negedge clock);
            s = sel == 0 ? link.status : sel == 1 ? busy : sel == 2 ? motor_run : link.cmd;
            if (s === v) return;
        end
        fails++;
        $display("unexpected wait %0d: expected %0b, seen timeout", sel, v);
        give_verdict();
    endtask
    // Raises a request and waits for its pulse to start.
    task automatic send_start(cmd_t c);
        @(posedge clock);
        req <= 1'b1;
        req_cmd <= c;
        wait_for(1, 1'b1, 8);
        @(posedge clock);
        req <= 1'b0;
        wait_for(3, 1'b1, 25000);
        rise_t = $time;
    endtask
    // Hands one command to the controller end and waits for its pulse to end.
    task automatic send(cmd_t c);
        send_start(c);
        wait_for(1, 1'b0, 6000 * T);
        fall_t = $time;
    endtask
    // Plays the motor: checks the run, ends it after len cycles, checks the status.
    task automatic run(logic body, logic fault, int len);
        wait_for(2, 1'b1, 300 * T);
        chk("status in run", 0, link.status);
        chk("pump body", body, motor_body);
        repeat (len) @(posedge clock);
        motor_done <= 1'b1;
        motor_fault <= fault;
        @(posedge clock);
        motor_done <= 1'b0;
        motor_fault <= 1'b0;
        repeat (3) @(negedge clock);
        chk("status after run", !fault, link.status);
    endtask
    // Sends a raw pulse of some ticks on the spare link; it must be ignored.
    task automatic pulse_b(int ticks);
        @(posedge clock);
        spare.cmd <= 1'b1;
        repeat (ticks * T) @(posedge clock);
        spare.cmd <= 1'b0;
        repeat (6) @(negedge clock);
        chk("spare status", 1, spare.status);
    endtask
    // Main sequence: refusals, single, dual with fault, bulk fill with stop.
    initial begin
        spare.cmd = 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        pulse_b(350);
        pulse_b(1600);
        send(CMD_PB1);
        run(BODY_FIRST, 1'b0, 20);
        chk("last command", CMD_PB1, last_cmd);
        send(CMD_PB2);
        run(BODY_SECOND, 1'b0, 700 * T);
        chk("last command", CMD_PB2, last_cmd);
        mark_t = fall_t;
        send(CMD_BOTH);
        chk("spacing", 1, rise_t - mark_t >= (2500 * T - 2 * T) * 25);
        mark_t = fall_t;
        run(BODY_FIRST, 1'b0, 20);
        run(BODY_SECOND, 1'b1, 20);
        repeat (400 * T) @(negedge clock);
        chk("error held", 0, link.status);
        send(CMD_ACK);
        repeat (4) @(negedge clock);
        chk("acknowledged", 1, link.status);
        send(CMD_FILL);
        chk("spacing 8 s", 1, rise_t - mark_t >= (4700 * T - 2 * T) * 25);
        run(BODY_FIRST, 1'b0, 20);
        chk("fill flag", 1, fill_active);
        wait_for(2, 1'b1, 300 * T);
        send_start(CMD_ACK);
        run(BODY_SECOND, 1'b0, 1300 * T);
        wait_for(1, 1'b0, 6000 * T);
        repeat (400 * T) @(negedge clock);
        chk("stop command", CMD_ACK, last_cmd);
        chk("no further run", 0, motor_run);
        chk("fill stopped", 0, fill_active);
        give_verdict();
    end
endmodule
